// >>> logic/clock_source_controller.sv
// Purpose: clock source enables, stable timing, system clock select, power-down, fail detect
// Assumes: oscillator pins are asynchronous to mclk; wfi and wake come from mclk logic
// Notes:   system clock choice is shown as a one-hot gate set, switched break-before-make
//
// Summary of operation
// - power-down needs the enable bit set and then a wait-for-interrupt
// - stay powered down until a wake-up interrupt, then leave
// - power-down stops high-speed crystal, 22 MHz and 48 MHz oscillators
// - PLL reference selects high-speed crystal or 22 MHz oscillator
// - enabling a source starts its counter; flag sets at its count
// - stable flags sit at status bits 0 to 5 in source order
// - high-speed crystal is stable after 4096 of its cycles
// - PLL count is 6144 or 12288 by select bit, default 12288
// - 48 MHz oscillator counts 512, 22 MHz oscillator counts 256
// - low-speed sources are stable after one own cycle
// - a source is used as clock only while its flag is one
// - disabling a source or powering down the PLL clears its flag
// - power-down clears crystal, 22 MHz and PLL flags; recount after wake
// - system clock picked from six sources by select bits 2:0
// - two crystal fail detectors, each with enable and interrupt enable
// - crystal detectors force on the matching RC oscillator
// - high-speed crystal stop moves system clock to the 22 MHz oscillator
// - high-speed crystal stop sets fail flag bit 0; interrupt if bit 5 set
`timescale 1ns/100ps
module clock_source_controller
   import clkctl_pkg::*;
#(
   parameter int PLL_CNT_SHORT = PLL_STABLE_SHORT,
   parameter int PLL_CNT_LONG  = PLL_STABLE_LONG,
   parameter int HXT_CNT       = HXT_STABLE_CNT,
   parameter int HXT_FAIL_LIM  = HXT_FAIL_CYC,
   parameter int LXT_FAIL_LIM  = LXT_FAIL_CYC
) (
   // clock and reset
   input  wire logic      mclk,
   input  wire logic      reset,
   // register bus
   input  wire axil_req_s axil_req,
   output axil_rsp_s      axil_rsp,
   // oscillator clocks, asynchronous
   input  wire logic      hxt_clk_pin,
   input  wire logic      lxt_clk_pin,
   input  wire logic      lrc_clk_pin,
   input  wire logic      rc22m_clk_pin,
   input  wire logic      rc48m_clk_pin,
   input  wire logic      pll_clk_pin,
   // processor
   input  wire logic      wfi_sleep,
   input  wire logic      wakeup_irq,
   // clock control outputs
   output logic [5:0]     osc_enable,
   output logic           pll_ref_is_rc22m,
   output logic [5:0]     sys_clk_gate,
   output logic           power_down,
   output logic           clk_fail_irq
);

   // register file
   logic [31:0]   pwrctl_r, clksel0_r, pllctl_r, clkdctl_r, clkdsts_r;
   logic [31:0]   pwrctl_nxt, clksel0_nxt, pllctl_nxt, clkdctl_nxt, clkdsts_nxt;
   // bus state
   logic          aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
   logic [7:0]    awaddr_r;
   logic [31:0]   wdata_r, rdata_r;
   logic [3:0]    wstrb_r;
   logic [1:0]    bresp_r, rresp_r, gap_cnt_r;
   // power and switching
   pwr_state_e    pstate_r;
   sw_state_e     sw_state_r;
   sys_src_e      cur_src_r;
   logic [5:0]    osc_en_r, gate_r;
   logic          ref_rc22_r, pd_r, irq_r;
   // fail detect
   logic [FAIL_CW-1:0] hxt_idle_r, lxt_idle_r;
   // synchronisers, index = source
   logic [2:0]    sync_r [NUM_SRC];
   logic [5:0]    tick, stable;

   // field decode
   wire sys_src_e sel_req      = sys_src_e'(clksel0_r[2:0]);
   wire           sleep_en     = pwrctl_r[PWR_SLEEP_EN];
   wire           hxt_det      = clkdctl_r[DCTL_HXT_DET];
   wire           lxt_det      = clkdctl_r[DCTL_LXT_DET];
   wire           pll_ref_rc22 = pllctl_r[PLL_REF_BIT];
   wire           in_pd        = (pstate_r == PS_DOWN);

   // effective enables: detectors force RC on, power-down stops fast sources
   wire           en_hxt  = pwrctl_r[PWR_HXT_EN] && !in_pd;
   wire           en_rc22 = (pwrctl_r[PWR_RC22_EN] || hxt_det) && !in_pd;
   wire           en_rc48 = pwrctl_r[PWR_RC48_EN] && !in_pd;
   wire           en_lrc  = pwrctl_r[PWR_LRC_EN] || lxt_det;
   wire           en_lxt  = pwrctl_r[PWR_LXT_EN];
   wire           en_pll  = !pllctl_r[PLL_PD_BIT] && !in_pd;
   wire [5:0]     run_vec = {en_rc48, en_rc22, en_lrc, en_pll, en_lxt, en_hxt};

   // stable targets per source
   wire [STB_CW-1:0] tgt [NUM_SRC];
   assign tgt[SRC_HXT]  = STB_CW'(HXT_CNT);
   assign tgt[SRC_LXT]  = STB_CW'(LOW_STABLE_CNT);
   assign tgt[SRC_PLL]  = pllctl_r[PLL_CNTSEL_BIT] ?
                          STB_CW'(PLL_CNT_LONG) : STB_CW'(PLL_CNT_SHORT);
   assign tgt[SRC_LRC]  = STB_CW'(LOW_STABLE_CNT);
   assign tgt[SRC_RC22] = STB_CW'(RC22_STABLE_CNT);
   assign tgt[SRC_RC48] = STB_CW'(RC48_STABLE_CNT);

   // oscillator pins: two flops, then edge detect on the second and third
   wire [5:0] pins = {rc48m_clk_pin, rc22m_clk_pin, lrc_clk_pin,
                      pll_clk_pin, lxt_clk_pin, hxt_clk_pin};

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         always_ff @(posedge mclk) begin
            if (reset) begin
               sync_r[g] <= 3'h0;
            end else begin
               sync_r[g] <= {sync_r[g][1:0], pins[g]};
            end
         end
         assign tick[g] = sync_r[g][1] && !sync_r[g][2];
      end
   endgenerate

   // PLL counts cycles of its reference clock
   wire [5:0] cnt_tick = {tick[SRC_RC48], tick[SRC_RC22], tick[SRC_LRC],
                          pll_ref_rc22 ? tick[SRC_RC22] : tick[SRC_HXT],
                          tick[SRC_LXT], tick[SRC_HXT]};

   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_stb
         osc_stable_timer #(
            .CW     (STB_CW)
         ) u_timer (
            .mclk   (mclk),
            .reset  (reset),
            .run    (run_vec[g]),
            .tick   (cnt_tick[g]),
            .target (tgt[g]),
            .stable (stable[g])
         );
      end
   endgenerate

   // clock fail detectors: no crystal edge for the timeout while it is up
   wire hxt_mon  = hxt_det && stable[SRC_HXT];
   wire lxt_mon  = lxt_det && stable[SRC_LXT];
   wire hxt_fail = hxt_mon && !tick[SRC_HXT] &&
                   (hxt_idle_r == FAIL_CW'(HXT_FAIL_LIM - 1));
   wire lxt_fail = lxt_mon && !tick[SRC_LXT] &&
                   (lxt_idle_r == FAIL_CW'(LXT_FAIL_LIM - 1));

   always_ff @(posedge mclk) begin
      if (reset || !hxt_mon || tick[SRC_HXT]) begin
         hxt_idle_r <= '0;
      end else if (hxt_idle_r != FAIL_CW'(HXT_FAIL_LIM)) begin
         hxt_idle_r <= hxt_idle_r + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || !lxt_mon || tick[SRC_LXT]) begin
         lxt_idle_r <= '0;
      end else if (lxt_idle_r != FAIL_CW'(LXT_FAIL_LIM)) begin
         lxt_idle_r <= lxt_idle_r + 1'b1;
      end
   end

   // high-speed crystal fail pulls the system clock off a high-speed-crystal-fed source
   wire on_hxt = (sel_req == SEL_HXT) || ((sel_req == SEL_PLL) && !pll_ref_rc22);
   wire force_rc22 = hxt_fail && on_hxt;

   // AXI4-Lite write path
   wire        wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
   wire [31:0] wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                          {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire        wr_pwr  = wr_fire && (awaddr_r == OFS_PWRCTL);
   wire        wr_sel  = wr_fire && (awaddr_r == OFS_CLKSEL0);
   wire        wr_pll  = wr_fire && (awaddr_r == OFS_PLLCTL);
   wire        wr_dctl = wr_fire && (awaddr_r == OFS_CLKDCTL);
   wire        wr_dsts = wr_fire && (awaddr_r == OFS_CLKDSTS);
   wire        wr_map  = wr_pwr || wr_sel || wr_pll || wr_dctl || wr_dsts ||
                         (awaddr_r == OFS_STATUS);
   wire [31:0] pw_m = wmask & PWRCTL_WMASK;
   wire [31:0] sl_m = wmask & CLKSEL0_WMASK;
   wire [31:0] pl_m = wmask & PLLCTL_WMASK;
   wire [31:0] dc_m = wmask & CLKDCTL_WMASK;
   wire [31:0] dsts_clr = wr_dsts ? (wdata_r & wmask & CLKDSTS_W1C) : 32'h0;
   wire [31:0] dsts_set = (32'(hxt_fail) << DSTS_HXT_FAIL) |
                          (32'(lxt_fail) << DSTS_LXT_FAIL);

   assign pwrctl_nxt  = wr_pwr ? ((pwrctl_r & ~pw_m) | (wdata_r & pw_m)) : pwrctl_r;
   assign clksel0_nxt = force_rc22 ? {29'h0, SEL_RC22} :
                        wr_sel ? ((clksel0_r & ~sl_m) | (wdata_r & sl_m)) : clksel0_r;
   assign pllctl_nxt  = wr_pll ? ((pllctl_r & ~pl_m) | (wdata_r & pl_m)) : pllctl_r;
   assign clkdctl_nxt = wr_dctl ? ((clkdctl_r & ~dc_m) | (wdata_r & dc_m)) : clkdctl_r;
   assign clkdsts_nxt = (clkdsts_r & ~dsts_clr) | dsts_set;  // set wins over clear

   always_ff @(posedge mclk) begin
      if (reset) begin
         pwrctl_r  <= PWRCTL_RST;
         clksel0_r <= CLKSEL0_RST;
         pllctl_r  <= PLLCTL_RST;
         clkdctl_r <= CLKDCTL_RST;
         clkdsts_r <= CLKDSTS_RST;
      end else begin
         pwrctl_r  <= pwrctl_nxt;
         clksel0_r <= clksel0_nxt;
         pllctl_r  <= pllctl_nxt;
         clkdctl_r <= clkdctl_nxt;
         clkdsts_r <= clkdsts_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
      end else begin
         if (axil_req.awvalid && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= axil_req.awaddr;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
         if (axil_req.wvalid && !w_hold_r) begin
            w_hold_r <= 1'b1;
            wdata_r  <= axil_req.wdata;
            wstrb_r  <= axil_req.wstrb;
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else if (axil_req.bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // AXI4-Lite read path
   wire [7:0]  ra      = axil_req.araddr;
   wire        rd_fire = axil_req.arvalid && !rvalid_r;
   wire        rd_map  = (ra == OFS_PWRCTL) || (ra == OFS_STATUS) ||
                         (ra == OFS_CLKSEL0) || (ra == OFS_PLLCTL) ||
                         (ra == OFS_CLKDCTL) || (ra == OFS_CLKDSTS);
   wire [31:0] rd_mux  = (ra == OFS_PWRCTL)  ? pwrctl_r :
                         (ra == OFS_STATUS)  ? {26'h0, stable} :
                         (ra == OFS_CLKSEL0) ? clksel0_r :
                         (ra == OFS_PLLCTL)  ? pllctl_r :
                         (ra == OFS_CLKDCTL) ? clkdctl_r :
                         (ra == OFS_CLKDSTS) ? clkdsts_r : 32'h0;

   always_ff @(posedge mclk) begin
      if (reset) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req.rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign axil_rsp.awready = !aw_hold_r;
   assign axil_rsp.wready  = !w_hold_r;
   assign axil_rsp.bvalid  = bvalid_r;
   assign axil_rsp.bresp   = bresp_r;
   assign axil_rsp.arready = !rvalid_r;
   assign axil_rsp.rvalid  = rvalid_r;
   assign axil_rsp.rdata   = rdata_r;
   assign axil_rsp.rresp   = rresp_r;

   // power-down sequencing
   always_ff @(posedge mclk) begin
      if (reset) begin
         pstate_r <= PS_RUN;
      end else begin
         case (pstate_r)
            PS_RUN: begin
               if (sleep_en && wfi_sleep) begin
                  pstate_r <= PS_DOWN;
               end
            end
            PS_DOWN: begin
               if (wakeup_irq) begin
                  pstate_r <= PS_RUN;
               end
            end
            default: pstate_r <= PS_RUN;
         endcase
      end
   end

   // system clock switch: all gates off for a gap, then the new one, only when stable
   wire [2:0] req_idx = (sel_req == SEL_HXT)  ? 3'(SRC_HXT)  :
                        (sel_req == SEL_LXT)  ? 3'(SRC_LXT)  :
                        (sel_req == SEL_PLL)  ? 3'(SRC_PLL)  :
                        (sel_req == SEL_LRC)  ? 3'(SRC_LRC)  :
                        (sel_req == SEL_RC48) ? 3'(SRC_RC48) : 3'(SRC_RC22);
   wire [2:0] cur_idx = (cur_src_r == SEL_HXT)  ? 3'(SRC_HXT)  :
                        (cur_src_r == SEL_LXT)  ? 3'(SRC_LXT)  :
                        (cur_src_r == SEL_PLL)  ? 3'(SRC_PLL)  :
                        (cur_src_r == SEL_LRC)  ? 3'(SRC_LRC)  :
                        (cur_src_r == SEL_RC48) ? 3'(SRC_RC48) : 3'(SRC_RC22);
   wire       req_ok  = stable[req_idx];
   wire       go_sw   = (sel_req != cur_src_r) && req_ok;
   wire [5:0] cur_hot = 6'h01 << cur_idx;

   always_ff @(posedge mclk) begin
      if (reset) begin
         sw_state_r <= SW_IDLE;
         cur_src_r  <= SEL_RC22;
         gap_cnt_r  <= 2'h0;
      end else begin
         case (sw_state_r)
            SW_IDLE: begin
               if (go_sw) begin
                  sw_state_r <= SW_GAP;
                  gap_cnt_r  <= 2'(SWITCH_GAP_CYC - 1);
               end
            end
            SW_GAP: begin
               if (gap_cnt_r != 2'h0) begin
                  gap_cnt_r <= gap_cnt_r - 1'b1;
               end else begin
                  sw_state_r <= SW_IDLE;
                  cur_src_r  <= sel_req;
               end
            end
            default: sw_state_r <= SW_IDLE;
         endcase
      end
   end

   wire gate_on = (sw_state_r == SW_IDLE) && !go_sw && !in_pd && stable[cur_idx];

   always_ff @(posedge mclk) begin
      if (reset) begin
         osc_en_r   <= 6'h00;
         gate_r     <= 6'h00;
         ref_rc22_r <= 1'b1;
         pd_r       <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         osc_en_r   <= run_vec;
         gate_r     <= gate_on ? cur_hot : 6'h00;
         ref_rc22_r <= pll_ref_rc22;
         pd_r       <= in_pd;
         irq_r      <= (clkdsts_nxt[DSTS_HXT_FAIL] && clkdctl_r[DCTL_HXT_IE]) ||
                       (clkdsts_nxt[DSTS_LXT_FAIL] && clkdctl_r[DCTL_LXT_IE]);
      end
   end

   assign osc_enable       = osc_en_r;
   assign sys_clk_gate     = gate_r;
   assign pll_ref_is_rc22m = ref_rc22_r;
   assign power_down       = pd_r;
   assign clk_fail_irq     = irq_r;

endmodule : clock_source_controller

// >>> logic/clkctl_pkg.sv
// Purpose: shared constants, types and register map of the clock source controller
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   oscillator indices double as stable flag positions in the status word
package clkctl_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_PWRCTL  = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h0c;
   localparam logic [7:0] OFS_CLKSEL0 = 8'h10;
   localparam logic [7:0] OFS_PLLCTL  = 8'h20;
   localparam logic [7:0] OFS_CLKDCTL = 8'h70;
   localparam logic [7:0] OFS_CLKDSTS = 8'h74;

   // oscillator index = stable flag position
   localparam int SRC_HXT  = 0;
   localparam int SRC_LXT  = 1;
   localparam int SRC_PLL  = 2;
   localparam int SRC_LRC  = 3;
   localparam int SRC_RC22 = 4;
   localparam int SRC_RC48 = 5;
   localparam int NUM_SRC  = 6;

   // field positions
   localparam int PWR_HXT_EN     = 0;
   localparam int PWR_LXT_EN     = 1;
   localparam int PWR_RC22_EN    = 2;
   localparam int PWR_LRC_EN     = 3;
   localparam int PWR_SLEEP_EN   = 7;
   localparam int PWR_RC48_EN    = 13;
   localparam int PLL_PD_BIT     = 16;
   localparam int PLL_REF_BIT    = 19;
   localparam int PLL_CNTSEL_BIT = 23;
   localparam int DCTL_HXT_DET   = 4;
   localparam int DCTL_HXT_IE    = 5;
   localparam int DCTL_LXT_DET   = 12;
   localparam int DCTL_LXT_IE    = 13;
   localparam int DSTS_HXT_FAIL  = 0;
   localparam int DSTS_LXT_FAIL  = 1;

   // reset values and writable masks
   localparam logic [31:0] PWRCTL_RST    = 32'h0000_0004;
   localparam logic [31:0] PWRCTL_WMASK  = 32'h0000_208f;
   localparam logic [31:0] CLKSEL0_RST   = 32'h0000_0007;
   localparam logic [31:0] CLKSEL0_WMASK = 32'h0000_0007;
   localparam logic [31:0] PLLCTL_RST    = 32'h0089_0000;
   localparam logic [31:0] PLLCTL_WMASK  = 32'h0089_0000;
   localparam logic [31:0] CLKDCTL_RST   = 32'h0000_0000;
   localparam logic [31:0] CLKDCTL_WMASK = 32'h0000_3030;
   localparam logic [31:0] CLKDSTS_RST   = 32'h0000_0000;
   localparam logic [31:0] CLKDSTS_W1C   = 32'h0000_0003;

   // stabilisation counts in oscillator cycles
   localparam int STB_CW           = 14;
   localparam int HXT_STABLE_CNT   = 4096;
   localparam int PLL_STABLE_SHORT = 6144;
   localparam int PLL_STABLE_LONG  = 12288;
   localparam int RC48_STABLE_CNT  = 512;
   localparam int RC22_STABLE_CNT  = 256;
   localparam int LOW_STABLE_CNT   = 1;

   // timing in mclk cycles
   localparam int CLK_PERIOD_NS    = 50;
   localparam int HXT_FAIL_TIME_NS = 1000;
   localparam int LXT_FAIL_TIME_NS = 100000;
   localparam int HXT_FAIL_CYC     = (HXT_FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LXT_FAIL_CYC     = (LXT_FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAIL_CW          = 12;
   localparam int SWITCH_GAP_CYC   = 2;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      SEL_HXT  = 3'b000,
      SEL_LXT  = 3'b001,
      SEL_PLL  = 3'b010,
      SEL_LRC  = 3'b011,
      SEL_RC48 = 3'b100,
      SEL_RC22 = 3'b111
   } sys_src_e;

   typedef enum logic [0:0] {
      PS_RUN  = 1'b0,
      PS_DOWN = 1'b1
   } pwr_state_e;

   typedef enum logic [0:0] {
      SW_IDLE = 1'b0,
      SW_GAP  = 1'b1
   } sw_state_e;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axil_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_s;

endpackage : clkctl_pkg

// >>> logic/osc_stable_timer.sv
// Purpose: counts oscillator edges after enable and raises a stable flag
// Assumes: tick is a one-cycle pulse in the mclk domain
// Notes:   flag and count drop at once when run falls
`timescale 1ns/100ps
module osc_stable_timer #(
   parameter int CW = 14
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          reset,
   // control
   input  wire logic          run,
   input  wire logic          tick,
   input  wire logic [CW-1:0] target,
   // status
   output logic               stable
);

   logic [CW-1:0] cnt_r;
   logic          stable_r;
   wire  [CW-1:0] cnt_inc  = cnt_r + 1'b1;
   wire           reach    = tick && (cnt_inc == target);

   always_ff @(posedge mclk) begin
      if (reset || !run) begin
         cnt_r    <= '0;
         stable_r <= 1'b0;
      end else if (tick && !stable_r) begin
         cnt_r    <= cnt_inc;
         stable_r <= reach;
      end
   end

   assign stable = stable_r;

endmodule : osc_stable_timer

// >>> verif/clkctl_checker.sv
// Purpose: port checks of the clock source controller
// Assumes: one mclk domain
// Notes:   bound to the design top
`timescale 1ns/100ps
module clkctl_checker
   import clkctl_pkg::*;
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       reset,
   // register bus
   input wire axil_req_s  axil_req,
   input wire axil_rsp_s  axil_rsp,
   // processor and clock control
   input wire logic       wfi_sleep,
   input wire logic       wakeup_irq,
   input wire logic [5:0] osc_enable,
   input wire logic [5:0] sys_clk_gate,
   input wire logic       power_down
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_wr; axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
   endsequence
   property p_onehot; $onehot0(sys_clk_gate); endproperty
   a_onehot: assert property (p_onehot) else $error("gates overlap");
   property p_pdwfi; $rose(power_down) |->
      $past(wfi_sleep) || $past(wfi_sleep, 2) || $past(wfi_sleep, 3); endproperty
   a_pdwfi: assert property (p_pdwfi) else $error("sleep without wfi");
   property p_pdoff; power_down && $past(power_down) |->
      (osc_enable & 6'h35) == 6'h00 && sys_clk_gate == 6'h00; endproperty
   a_pdoff: assert property (p_pdoff) else $error("oscillator on in sleep");
   property p_wake; power_down && wakeup_irq |-> ##[1:3] !power_down; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_stay; $fell(power_down) |->
      $past(wakeup_irq) || $past(wakeup_irq, 2) || $past(wakeup_irq, 3); endproperty
   a_stay: assert property (p_stay) else $error("woke without irq");
   property p_bbm; sys_clk_gate != 6'h00 && !$stable(sys_clk_gate) |->
      $past(sys_clk_gate) == 6'h00 && $past(sys_clk_gate, 2) == 6'h00; endproperty
   a_bbm: assert property (p_bbm) else $error("switch without gap");
   property p_gate_en; (sys_clk_gate & ~osc_enable & ~$past(osc_enable)
      & ~$past(osc_enable, 2)) == 6'h00; endproperty
   a_gate_en: assert property (p_gate_en) else $error("gate on stopped source");
   property p_bresp; s_wr |-> ##2 axil_rsp.bvalid; endproperty
   a_bresp: assert property (p_bresp) else $error("late write response");
   property p_rd; axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid && !axil_rsp.arready;
   endproperty
   a_rd: assert property (p_rd) else $error("late read response");
endmodule : clkctl_checker
bind clock_source_controller clkctl_checker chk_i (.mclk, .reset, .axil_req, .axil_rsp,
   .wfi_sleep, .wakeup_irq, .osc_enable, .sys_clk_gate, .power_down);

// >>> verif/osc_partner.sv
// Purpose: oscillator models driving the controller pins
// Assumes: each half period exceeds one mclk period
// Notes:   a stopped oscillator rests at 0
`timescale 1ns/100ps
module osc_partner (
   // controls
   input  wire logic [5:0] osc_enable,
   input  wire logic       hxt_stop,
   // oscillator pins
   output logic [5:0]      osc_pin
);
   localparam int HALF [6] = '{115, 305, 75, 415, 85, 65};
   for (genvar i = 0; i < 6; i++) begin : g_osc
      wire logic run = osc_enable[i] && !(i == 0 && hxt_stop);
      initial osc_pin[i] = 1'b0;
      always #(HALF[i]) osc_pin[i] = run ? ~osc_pin[i] : 1'b0;
   end
endmodule : osc_partner

// >>> verif/test_clock_source_controller.sv
// Purpose: register level test of the clock source controller
// Assumes: short stable counts set by parameters
// Notes:   one read or write at a time
`timescale 1ns/100ps
module test_clock_source_controller;
   import clkctl_pkg::*;
   logic        mclk = 1'b0, reset = 1'b1, hxt_stop = 1'b0, wfi_sleep = 1'b0, wakeup_irq = 1'b0;
   axil_req_s   req = '0;
   axil_rsp_s   rsp;
   logic [5:0]  osc_pin, osc_enable, sys_clk_gate;
   logic        pll_ref_is_rc22m, power_down, clk_fail_irq;
   logic [31:0] rd;
   logic [1:0]  rr;
   int          n_mismatch = 0, cmp_count = 0;
   always #25 mclk = ~mclk;
   osc_partner far (.osc_enable, .hxt_stop, .osc_pin);
   clock_source_controller #(.HXT_CNT(8), .PLL_CNT_SHORT(4), .PLL_CNT_LONG(8), .LXT_FAIL_LIM(20))
      dut (.mclk, .reset, .axil_req(req), .axil_rsp(rsp), .hxt_clk_pin(osc_pin[0]),
      .lxt_clk_pin(osc_pin[1]), .pll_clk_pin(osc_pin[2]), .lrc_clk_pin(osc_pin[3]),
      .rc22m_clk_pin(osc_pin[4]), .rc48m_clk_pin(osc_pin[5]), .wfi_sleep, .wakeup_irq,
      .osc_enable, .pll_ref_is_rc22m, .sys_clk_gate, .power_down, .clk_fail_irq);
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req <= '{awaddr:a, awvalid:1'b1, wdata:d, wstrb:4'hf, wvalid:1'b1, bready:1'b1, default:'0};
      while (rsp.bvalid !== 1'b1) begin
         @(posedge mclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end
      chk("bresp", {30'h0, rsp.bresp}, {30'h0, RESP_OKAY});
      req.bready <= 1'b0;
   endtask : wr
   task automatic rdt(input logic [7:0] a);
      @(posedge mclk);
      req <= '{araddr:a, arvalid:1'b1, rready:1'b1, default:'0};
      while (rsp.rvalid !== 1'b1) begin
         @(posedge mclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end
      rd = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
   endtask : rdt
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      rdt(a);
      chk(n, rd, e);
   endtask : rchk
   task automatic wbit(input int b);
      rd = '0;
      for (int i = 0; i < 600 && rd[b] !== 1'b1; i++) rdt(OFS_STATUS);
      chk("stable flag", {31'h0, rd[b]}, 32'h1);
   endtask : wbit
   task automatic wgate(input logic [5:0] g);
      for (int i = 0; i < 40 && sys_clk_gate !== g; i++) @(posedge mclk);
      chk("gate", {26'h0, sys_clk_gate}, {26'h0, g});
   endtask : wgate
   task automatic sleep(input logic e);
      @(posedge mclk);
      wfi_sleep <= 1'b1;
      @(posedge mclk);
      wfi_sleep <= 1'b0;
      for (int i = 0; i < 6 && power_down !== 1'b1; i++) @(posedge mclk);
      chk("power down", {31'h0, power_down}, {31'h0, e});
   endtask : sleep
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   initial begin : watchdog
      #2000000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin : main
      logic [7:0]  ofs [5];
      logic [31:0] rst [5];
      ofs = '{OFS_PWRCTL, OFS_CLKSEL0, OFS_PLLCTL, OFS_CLKDCTL, OFS_CLKDSTS};
      rst = '{PWRCTL_RST, CLKSEL0_RST, PLLCTL_RST, CLKDCTL_RST, CLKDSTS_RST};
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++) rchk("reset value", ofs[i], rst[i]);
      chk("pll ref reset", {31'h0, pll_ref_is_rc22m}, 32'h1);
      rdt(8'h04);
      chk("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
      wbit(SRC_RC22);
      wgate(6'h10);
      wr(OFS_PWRCTL, 32'h0000_200f);
      wbit(SRC_HXT);
      wbit(SRC_LXT);
      wbit(SRC_LRC);
      wbit(SRC_RC48);
      rchk("status", OFS_STATUS, 32'h0000_003b);
      wr(OFS_PLLCTL, 32'h0000_0000);
      wbit(SRC_PLL);
      chk("pll ref", {31'h0, pll_ref_is_rc22m}, 32'h0);
      wr(OFS_CLKSEL0, {29'h0, SEL_PLL});
      wgate(6'h04);
      wr(OFS_PWRCTL, 32'h0000_2007);
      rchk("source off", OFS_STATUS, 32'h0000_0037);
      wr(OFS_CLKDCTL, 32'h0000_0030);
      hxt_stop <= 1'b1;
      for (int i = 0; i < 100 && clk_fail_irq !== 1'b1; i++) @(posedge mclk);
      chk("fail irq", {31'h0, clk_fail_irq}, 32'h1);
      rchk("fail flag", OFS_CLKDSTS, 32'h1);
      rchk("fallback", OFS_CLKSEL0, 32'h7);
      wgate(6'h10);
      hxt_stop <= 1'b0;
      wr(OFS_PWRCTL, 32'h0000_2002);
      rchk("enables", OFS_PWRCTL, 32'h0000_2002);
      chk("rc22m forced", {31'h0, osc_enable[SRC_RC22]}, 32'h1);
      wr(OFS_PWRCTL, 32'h0000_2007);
      wbit(SRC_HXT);
      wr(OFS_CLKDSTS, 32'h1);
      rchk("fail clear", OFS_CLKDSTS, 32'h0);
      chk("irq clear", {31'h0, clk_fail_irq}, 32'h0);
      wr(OFS_CLKSEL0, 32'h0);
      wgate(6'h01);
      wr(OFS_CLKDCTL, 32'h0);
      sleep(1'b0);
      wr(OFS_PWRCTL, 32'h0000_2087);
      rchk("enable alone", OFS_PWRCTL, 32'h0000_2087);
      chk("awake", {31'h0, power_down}, 32'h0);
      sleep(1'b1);
      rdt(OFS_STATUS);
      chk("sleep flags", rd & 32'h15, 32'h0);
      chk("sleep osc", {26'h0, osc_enable & 6'h35}, 32'h0);
      chk("still down", {31'h0, power_down}, 32'h1);
      @(posedge mclk);
      wakeup_irq <= 1'b1;
      @(posedge mclk);
      wakeup_irq <= 1'b0;
      for (int i = 0; i < 8 && power_down !== 1'b0; i++) @(posedge mclk);
      chk("woken", {31'h0, power_down}, 32'h0);
      wbit(SRC_HXT);
      wbit(SRC_PLL);
      report_and_stop();
   end
endmodule : test_clock_source_controller
